// File: verilog/bpsr_pkg.sv
/*
  Constants shared by the buck-pair set-point register bank: register
  offsets, field positions, reset values and mode codes.
  Assumes an 8-bit register address and 8-bit register data.
*/
package bpsr_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] BPSR_OFF_A_NORMAL = 8'h3C;
  localparam logic [7:0] BPSR_OFF_A_STANDBY = 8'h3D;
  localparam logic [7:0] BPSR_OFF_A_SLEEP = 8'h3E;
  localparam logic [7:0] BPSR_OFF_A_MODE = 8'h3F;
  localparam logic [7:0] BPSR_OFF_A_CONFIG = 8'h40;
  localparam logic [7:0] BPSR_OFF_B_NORMAL = 8'h43;
  localparam logic [7:0] BPSR_OFF_B_STANDBY = 8'h44;
  localparam logic [7:0] BPSR_OFF_B_SLEEP = 8'h45;
  localparam logic [7:0] BPSR_OFF_B_MODE = 8'h46;
  localparam logic [7:0] BPSR_OFF_B_CONFIG = 8'h47;
  // distance from an output-a register to its output-b twin
  localparam logic [7:0] BPSR_B_STRIDE = 8'h07;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int BPSR_CODE_MSB = 5;
  localparam int BPSR_RANGE_BIT = 6;
  localparam logic [7:0] BPSR_CODE_MASK = 8'h3F;
  localparam logic [7:0] BPSR_MODE_MASK = 8'h2F;
  localparam logic [7:0] BPSR_CONFIG_MASK = 8'hFF;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [5:0] BPSR_CODE_RESET = 6'h00;
  localparam logic [7:0] BPSR_MODE_RESET = 8'h00;
  localparam logic [7:0] BPSR_CONFIG_RESET = 8'h00;
  localparam logic BPSR_RANGE_RESET = 1'h0;
  localparam logic [7:0] BPSR_READ_UNMAPPED = 8'h00;

  // ----------------------------------------------------------------
  // power modes that pick the active set point
  // ----------------------------------------------------------------
  localparam logic [1:0] BPSR_PMODE_NORMAL = 2'h0;
  localparam logic [1:0] BPSR_PMODE_STANDBY = 2'h1;
  localparam logic [1:0] BPSR_PMODE_SLEEP = 2'h2;

endpackage

// File: verilog/bpsr_setpoint_set.sv
/*
  One output's three set-point registers (normal, standby, sleep) plus
  the range bit shared by all three, and the selection of the active code.
  Assumes write strobes come from the bank's address decode on clk_sys.
*/
`timescale 1ns/1ps
module bpsr_setpoint_set
  import bpsr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [2:0] wr_sel,
  input wire logic [7:0] wr_data,
  input wire logic range_load,
  input wire logic range_value,
  input wire logic [1:0] power_mode,
  output logic [7:0] normal_q,
  output logic [7:0] standby_q,
  output logic [7:0] sleep_q,
  output logic [6:0] active_setpoint
);

  logic [5:0] code_reg [0:2];
  logic range_reg;
  logic [5:0] active_code;

  // ----------------------------------------------------------------
  // writable codes, one per power mode
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_code
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          code_reg[i] <= BPSR_CODE_RESET;
        end else if (wr_sel[i]) begin
          code_reg[i] <= wr_data[BPSR_CODE_MSB:0];
        end
      end
    end
  endgenerate

  // range bit is never touched by bus writes; only the configuration
  // load sets it, and standby/sleep reuse the same flop so they inherit it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      range_reg <= BPSR_RANGE_RESET;
    end else if (range_load) begin
      range_reg <= range_value;
    end
  end

  assign normal_q = {1'b0, range_reg, code_reg[0]};
  assign standby_q = {1'b0, range_reg, code_reg[1]};
  assign sleep_q = {1'b0, range_reg, code_reg[2]};

  // ----------------------------------------------------------------
  // active set point for the regulator
  // ----------------------------------------------------------------
  assign active_code = (power_mode == BPSR_PMODE_STANDBY) ? code_reg[1] :
                       (power_mode == BPSR_PMODE_SLEEP) ? code_reg[2] :
                       code_reg[0];
  // range 0: 0.40 V + 25 mV steps, range 1: 0.80 V + 50 mV steps
  assign active_setpoint = {range_reg, active_code};

endmodule // bpsr_setpoint_set

// File: verilog/bpsr_bank.sv
/*
  Register bank for a dual buck regulator pair: set points per power
  mode, switching mode and configuration registers for each output.
  Assumes a simple synchronous register port from the serial control
  bus decoder on clk_sys, and a one-cycle configuration load strobe.
*/
`timescale 1ns/1ps
module bpsr_bank
  import bpsr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic trial_config_load,
  input wire logic cfg_range_a,
  input wire logic cfg_range_b,
  input wire logic single_phase,
  input wire logic [1:0] power_mode,
  output logic [6:0] buck_out_a_setpoint,
  output logic [6:0] buck_out_b_setpoint,
  output logic [7:0] out_a_switch_mode,
  output logic [7:0] out_a_config,
  output logic [7:0] out_b_switch_mode,
  output logic [7:0] out_b_config
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic [4:0] bpsr_decode(input logic [7:0] addr, input logic [7:0] base);
    logic [4:0] hit;
    hit = 5'h00;
    if (addr == base) hit[0] = 1'b1;
    if (addr == base + 8'h01) hit[1] = 1'b1;
    if (addr == base + 8'h02) hit[2] = 1'b1;
    if (addr == base + 8'h03) hit[3] = 1'b1;
    if (addr == base + 8'h04) hit[4] = 1'b1;
    return hit;
  endfunction

  wire [4:0] hit_a = bpsr_decode(reg_addr, BPSR_OFF_A_NORMAL);
  wire [4:0] hit_b = bpsr_decode(reg_addr, BPSR_OFF_A_NORMAL + BPSR_B_STRIDE);
  wire [4:0] wr_a = hit_a & {5{reg_wr}};
  wire [4:0] wr_b = hit_b & {5{reg_wr}};

  logic [7:0] mode_a_reg;
  logic [7:0] conf_a_reg;
  logic [7:0] mode_b_reg;
  logic [7:0] conf_b_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  logic [7:0] a_norm_q;
  logic [7:0] a_stby_q;
  logic [7:0] a_slp_q;
  logic [7:0] b_norm_q;
  logic [7:0] b_stby_q;
  logic [7:0] b_slp_q;
  logic [6:0] a_active;
  logic [6:0] b_active;

  // ----------------------------------------------------------------
  // set-point registers
  // ----------------------------------------------------------------
  bpsr_setpoint_set u_set_a (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_sel(wr_a[2:0]),
    .wr_data(reg_wdata),
    .range_load(trial_config_load),
    .range_value(cfg_range_a),
    .power_mode(power_mode),
    .normal_q(a_norm_q),
    .standby_q(a_stby_q),
    .sleep_q(a_slp_q),
    .active_setpoint(a_active)
  );

  bpsr_setpoint_set u_set_b (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_sel(wr_b[2:0]),
    .wr_data(reg_wdata),
    .range_load(trial_config_load),
    .range_value(cfg_range_b),
    .power_mode(power_mode),
    .normal_q(b_norm_q),
    .standby_q(b_stby_q),
    .sleep_q(b_slp_q),
    .active_setpoint(b_active)
  );

  assign buck_out_a_setpoint = a_active;
  // combined output follows output a; b's own codes are kept but unused
  assign buck_out_b_setpoint = single_phase ? a_active : b_active;

  // ----------------------------------------------------------------
  // mode and configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_a_reg <= BPSR_MODE_RESET;
      conf_a_reg <= BPSR_CONFIG_RESET;
      mode_b_reg <= BPSR_MODE_RESET;
      conf_b_reg <= BPSR_CONFIG_RESET;
    end else begin
      if (wr_a[3]) mode_a_reg <= reg_wdata & BPSR_MODE_MASK;
      if (wr_a[4]) conf_a_reg <= reg_wdata & BPSR_CONFIG_MASK;
      if (wr_b[3]) mode_b_reg <= reg_wdata & BPSR_MODE_MASK;
      if (wr_b[4]) conf_b_reg <= reg_wdata & BPSR_CONFIG_MASK;
    end
  end

  assign out_a_switch_mode = mode_a_reg;
  assign out_a_config = conf_a_reg;
  assign out_b_switch_mode = mode_b_reg;
  assign out_b_config = conf_b_reg;

  // ----------------------------------------------------------------
  // read path, one cycle latency; unmapped addresses read zero
  // ----------------------------------------------------------------
  assign rdata_next = hit_a[0] ? a_norm_q :
                      hit_a[1] ? a_stby_q :
                      hit_a[2] ? a_slp_q :
                      hit_a[3] ? mode_a_reg :
                      hit_a[4] ? conf_a_reg :
                      hit_b[0] ? b_norm_q :
                      hit_b[1] ? b_stby_q :
                      hit_b[2] ? b_slp_q :
                      hit_b[3] ? mode_b_reg :
                      hit_b[4] ? conf_b_reg :
                      BPSR_READ_UNMAPPED;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_reg <= BPSR_READ_UNMAPPED;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= reg_rd;
      if (reg_rd) rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;

endmodule // bpsr_bank

// File: testbench/bpsr_bank_monitor.sv
/*
  Port checker for the set-point bank.
  Bound onto bpsr_bank by the bind statement after the module.
*/
`timescale 1ns/1ps
module bpsr_bank_monitor
  import bpsr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic trial_config_load,
  input wire logic cfg_range_a,
  input wire logic single_phase,
  input wire logic [1:0] power_mode,
  input wire logic [6:0] buck_out_a_setpoint,
  input wire logic [6:0] buck_out_b_setpoint,
  input wire logic [7:0] out_a_switch_mode
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // shadow of output a codes, indexed by the offset's low bits
  // ----------------------------------------------------------------
  logic [5:0] code_reg [3];
  always_ff @(posedge clk_sys) begin
    if (rst)
      code_reg <= '{default: 6'h00};
    else if (reg_wr && reg_addr inside {8'h3C, 8'h3D, 8'h3E})
      code_reg[reg_addr[1:0]] <= reg_wdata[5:0];
  end
  AST_RVALID: assert property (1'b1 |=> reg_rvalid == $past(reg_rd))
    else $error("read valid not one cycle after read");
  AST_UNMAPPED: assert property (reg_rd && reg_addr inside {8'h41, 8'h42} |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_A_NORMAL: assert property (power_mode == 2'h0 |-> buck_out_a_setpoint[5:0] == code_reg[0])
    else $error("normal code not selected");
  AST_A_STBY: assert property (power_mode == 2'h1 |-> buck_out_a_setpoint[5:0] == code_reg[1])
    else $error("standby code not selected");
  AST_A_SLEEP: assert property (power_mode == 2'h2 |-> buck_out_a_setpoint[5:0] == code_reg[2])
    else $error("sleep code not selected");
  AST_RANGE_HOLD: assert property (!trial_config_load |=> $stable(buck_out_a_setpoint[6]))
    else $error("range bit moved without load");
  AST_RANGE_LOAD: assert property (trial_config_load |=> buck_out_a_setpoint[6] == $past(cfg_range_a))
    else $error("range bit not loaded");
  AST_SINGLE: assert property (single_phase |-> buck_out_b_setpoint == buck_out_a_setpoint)
    else $error("combined output not following a");
  AST_MODE: assert property (reg_wr && reg_addr == 8'h3F |=> out_a_switch_mode == ($past(reg_wdata) & BPSR_MODE_MASK))
    else $error("switch mode write wrong");
endmodule // bpsr_bank_monitor
bind bpsr_bank bpsr_bank_monitor bpsr_bank_monitor_i (.clk_sys, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
  .reg_rdata, .reg_rvalid, .trial_config_load, .cfg_range_a, .single_phase, .power_mode,
  .buck_out_a_setpoint, .buck_out_b_setpoint, .out_a_switch_mode);

// File: testbench/bpsr_host_model.sv
/*
  Host side of the register port: one write and one read task.
  Assumes the bank takes requests on the rising edge of clk_sys.
*/
`timescale 1ns/1ps
module bpsr_host_model
  import bpsr_pkg::*;
(
  input wire logic clk_sys,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // released lines show the inverse so stale values never look live
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
  endtask
endmodule // bpsr_host_model

// File: testbench/bpsr_bank_test.sv
/*
  Self-checking bench for the set-point bank.
  Assumes the host model drives the register port.
*/
`timescale 1ns/1ps
module bpsr_bank_test
  import bpsr_pkg::*;
;
  localparam logic [7:0] SA [6] = '{8'h3C, 8'h3D, 8'h3E, 8'h43, 8'h44, 8'h45};
  localparam logic [7:0] MA [5] = '{8'h3F, 8'h46, 8'h40, 8'h47, 8'h41};
  localparam logic [7:0] MD [5] = '{8'hFF, 8'hFF, 8'hA5, 8'h5A, 8'hFF};
  localparam logic [7:0] ME [5] = '{8'h2F, 8'h2F, 8'hA5, 8'h5A, 8'h00};
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic reg_wr, reg_rd, reg_rvalid, trial_config_load = 1'b0, cfg_range_a = 1'b0, cfg_range_b = 1'b0;
  logic single_phase = 1'b0;
  logic [1:0] power_mode = 2'h0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d, a_mode, a_conf, b_mode, b_conf;
  logic [6:0] sp_a, sp_b;
  logic [5:0] sp [6];
  int failures = 0, checked = 0, cycles = 0, k;
  always #5 clk_sys = ~clk_sys;
  bpsr_bank bpsr_bank_i (.clk_sys, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
    .trial_config_load, .cfg_range_a, .cfg_range_b, .single_phase, .power_mode,
    .buck_out_a_setpoint(sp_a), .buck_out_b_setpoint(sp_b), .out_a_switch_mode(a_mode),
    .out_a_config(a_conf), .out_b_switch_mode(b_mode), .out_b_config(b_conf));
  bpsr_host_model bpsr_host_model_i (.clk_sys, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid);
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // a run of about 100 cycles; the ceiling leaves ample margin
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      give_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    for (int i = 8'h3C; i <= 8'h47; i++) begin
      bpsr_host_model_i.rd(8'(i), d);
      check(d, 8'h00);
    end
    for (int i = 0; i < 6; i++) begin
      // codes 24..49 stay between 2.0 V and 3.3 V once a high range is loaded
      sp[i] = 6'(i * 5 + 24);
      bpsr_host_model_i.wr(SA[i], {2'b11, sp[i]});
    end
    cfg_range_a = 1'b1;
    trial_config_load = 1'b1;
    @(negedge clk_sys);
    trial_config_load = 1'b0;
    cfg_range_a = 1'b0;
    for (int i = 0; i < 6; i++) begin
      bpsr_host_model_i.rd(SA[i], d);
      check(d, {1'b0, i < 3, sp[i]});
    end
    bpsr_host_model_i.wr(8'h3C, {2'b10, sp[0]});
    bpsr_host_model_i.rd(8'h3C, d);
    check(d, {2'b01, sp[0]});
    for (int m = 0; m < 8; m++) begin
      power_mode = 2'(m);
      single_phase = m[2];
      @(negedge clk_sys);
      k = (m % 4 == 3) ? 0 : m % 4;
      check({1'b0, sp_a}, {2'b01, sp[k]});
      check({1'b0, sp_b}, m[2] ? {2'b01, sp[k]} : {2'b00, sp[k + 3]});
    end
    // second load swaps the ranges so both range inputs are seen at both levels
    cfg_range_b = 1'b1;
    trial_config_load = 1'b1;
    power_mode = 2'h0;
    single_phase = 1'b0;
    @(negedge clk_sys);
    trial_config_load = 1'b0;
    check({1'b0, sp_b}, {2'b01, sp[3]});
    bpsr_host_model_i.rd(8'h3C, d);
    check(d, {2'b00, sp[0]});
    bpsr_host_model_i.rd(8'h45, d);
    check(d, {2'b01, sp[5]});
    for (int i = 0; i < 5; i++) begin
      bpsr_host_model_i.wr(MA[i], MD[i]);
      bpsr_host_model_i.rd(MA[i], d);
      check(d, ME[i]);
    end
    check(a_mode, 8'h2F);
    check(b_mode, 8'h2F);
    check(a_conf, 8'hA5);
    check(b_conf, 8'h5A);
    give_verdict();
  end
endmodule // bpsr_bank_test
